// ===== sarsr_pkg.sv
// Package: shared types and constants of the serial SAR readout block
package sarsr_pkg;

	// Result width and conversion sequence figures
	localparam int          SARSR_CODE_W    = 12;
	localparam logic [11:0] SARSR_MIDSCALE  = 12'h800;
	localparam logic [11:0] SARSR_CODE_ZERO = 12'h000;
	localparam logic [4:0]  SARSR_NULL_EDGE = 5'h01;
	localparam logic [3:0]  SARSR_TOP_IDX   = 4'hb;
	localparam logic [3:0]  SARSR_REP_FIRST = 4'h1;
	localparam logic [3:0]  SARSR_REP_END   = 4'hc;
	localparam int          SARSR_SYNC_W    = 3;

	// Pin inputs from the host and the comparator
	typedef struct packed {
		logic select_shutdown_n;
		logic serial_bit_clock;
		logic comparator_high;
	} sarsr_pins_t;

	// Controls towards the analog section
	typedef struct packed {
		logic        analog_power;
		logic        sample_input;
		logic [11:0] trial_code;
	} sarsr_analog_t;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_SAMPLE,
		ST_CONVERT,
		ST_REPEAT,
		ST_DONE
	} sarsr_state_t;

endpackage

// ===== sarsr_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module sarsr_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

// ===== sarsr_core.sv
// Conversion sequencer and three-wire serial output of the 12-bit SAR converter
// Function
// R1 - Falling select starts a conversion and its transfer; sampling begins then.
// R2 - First one and a half to two bit clocks acquire input before deciding.
// R3 - Output tri-stated until second falling bit clock, then low null bit.
// R4 - Next twelve periods carry twelve decisions, top bit first.
// R5 - Output bit changes on each falling bit clock edge.
// R6 - Host captures on rising bit clock edge, falling only if hold allows.
// R7 - Further clocks after bottom bit resend result bottom bit first.
// R8 - After top bit repeated, output tri-states and later clocks are ignored.
// R9 - New conversion only after select goes high then low again.
// R10 - Shifted bits belong to this frame's conversion, no pipeline delay.
// R11 - Host keeps bit clock between 10 kHz and 3.2 MHz.
// R12 - At most 200,000 conversions per second, sixteen clocks per frame.
// R13 - Result is straight binary: FFF full scale, 800 mid, 000 zero.
// R14 - Select low operates; select high is full shutdown of both sections.
// R15 - Raising select early abandons the conversion and shuts down.
// R16 - Output is high impedance whenever select is high.
`timescale 1ns/1ps
module sarsr_core
	import sarsr_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk_in,
	input  wire logic                    rst_n_in,
	// Host pins and comparator
	input  wire sarsr_pkg::sarsr_pins_t  pins_in,
	// Serial output pin
	output logic                         serial_data_out,
	output logic                         serial_data_oe_out,
	// Analog section controls
	output sarsr_pkg::sarsr_analog_t     analog_out,
	// Digital section powered
	output logic                         digital_active_out
);
	import sarsr_pkg::*;

	sarsr_pins_t  pins_s;
	sarsr_state_t state_reg;
	sarsr_state_t state_next;
	logic         sck_prev_reg;
	logic         sel_prev_reg;
	logic [4:0]   edge_cnt_reg;
	logic [3:0]   bit_idx_reg;
	logic [11:0]  code_reg;
	logic [11:0]  code_next;

	// Pins cross into the system clock through two flip-flops
	sarsr_sync #(
		.WIDTH (SARSR_SYNC_W)
	) i_sarsr_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.async_in (pins_in),
		.sync_out (pins_s)
	);

	// Clears bit idx when the comparator rejects it, sets the next lower trial bit
	function automatic logic [11:0] sar_step(input logic [11:0] code, input logic [3:0] idx, input logic keep);
		logic [11:0] c;
		c = code;
		c[idx] = keep;
		if (idx != 4'h0) begin
			c[idx - 4'h1] = 1'b1;
		end
		return c;
	endfunction

	// Edge and level decode of the synchronised pins
	wire selected  = !pins_s.select_shutdown_n;
	wire sel_fall  = sel_prev_reg && selected; // R1 R9
	wire sck_fall  = sck_prev_reg && !pins_s.serial_bit_clock; // R5
	wire decided   = pins_s.comparator_high;
	wire rep_bit   = code_reg[bit_idx_reg];
	wire rep_last  = (bit_idx_reg == SARSR_REP_END);
	wire dec_last  = (bit_idx_reg == 4'h0);
	wire null_edge = (edge_cnt_reg == SARSR_NULL_EDGE);

	// Next trial code; straight binary, kept bit means input at or above the trial level
	assign code_next = sar_step(code_reg, bit_idx_reg, decided); // R13 R10

	// Sequencer next state; select high overrides everything
	always_comb begin
		state_next = state_reg;
		if (!selected) begin
			state_next = ST_OFF; // R14 R15
		end else begin
			unique case (state_reg)
				ST_OFF:     if (sel_fall) state_next = ST_SAMPLE; // R1 R9
				ST_SAMPLE:  if (sck_fall && null_edge) state_next = ST_CONVERT; // R2
				ST_CONVERT: if (sck_fall && dec_last) state_next = ST_REPEAT; // R4 R12
				ST_REPEAT:  if (sck_fall && rep_last) state_next = ST_DONE; // R8
				ST_DONE:    state_next = ST_DONE; // R8 R9
			endcase
		end
	end

	// Edge history; select starts as low so a device selected at reset waits for a toggle
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sck_prev_reg <= 1'b0;
			sel_prev_reg <= 1'b0;
			state_reg    <= ST_OFF;
		end else begin
			sck_prev_reg <= pins_s.serial_bit_clock;
			sel_prev_reg <= pins_s.select_shutdown_n;
			state_reg    <= state_next;
		end
	end

	// Falling edge count and bit index
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || state_next == ST_OFF) begin
			edge_cnt_reg <= 5'h00;
			bit_idx_reg  <= SARSR_TOP_IDX;
		end else if (sck_fall) begin
			if (state_reg == ST_SAMPLE) begin
				edge_cnt_reg <= edge_cnt_reg + 5'h01;
			end
			if (state_reg == ST_CONVERT) begin
				bit_idx_reg <= dec_last ? SARSR_REP_FIRST : bit_idx_reg - 4'h1;
			end else if (state_reg == ST_REPEAT && !rep_last) begin
				bit_idx_reg <= bit_idx_reg + 4'h1; // R7
			end
		end
	end

	// Successive-approximation code; trial starts at midscale on the null bit
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || state_next == ST_OFF) begin
			code_reg <= SARSR_CODE_ZERO;
		end else if (sck_fall && state_reg == ST_SAMPLE && null_edge) begin
			code_reg <= SARSR_MIDSCALE; // R13
		end else if (sck_fall && state_reg == ST_CONVERT) begin
			code_reg <= code_next; // R4 R10
		end
	end

	// Serial output; each decision goes out the moment it is made, so no latency
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || state_next == ST_OFF) begin
			serial_data_out    <= 1'b0;
			serial_data_oe_out <= 1'b0; // R16 R15
		end else if (sck_fall) begin
			unique case (state_reg)
				ST_SAMPLE: if (null_edge) begin
					serial_data_oe_out <= 1'b1; // R3
					serial_data_out    <= 1'b0;
				end
				ST_CONVERT: serial_data_out <= decided; // R4 R10
				ST_REPEAT: if (rep_last) begin
					serial_data_oe_out <= 1'b0; // R8
				end else begin
					serial_data_out <= rep_bit; // R7
				end
				ST_OFF, ST_DONE: serial_data_out <= serial_data_out;
			endcase
		end
	end

	// Trial code seen by the array in the cycle after an update
	function automatic logic [11:0] code_next_view();
		if (sck_fall && state_reg == ST_SAMPLE) begin
			return SARSR_MIDSCALE;
		end
		if (sck_fall && state_reg == ST_CONVERT) begin
			return code_next;
		end
		return code_reg;
	endfunction

	// Analog section runs only during acquire and decide; digital while selected and out of ST_OFF
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			analog_out         <= '0;
			digital_active_out <= 1'b0;
		end else begin
			analog_out.analog_power <= (state_next == ST_SAMPLE) || (state_next == ST_CONVERT); // R14
			analog_out.sample_input <= (state_next == ST_SAMPLE); // R2
			analog_out.trial_code   <= (state_next == ST_CONVERT) ? code_next_view() : SARSR_CODE_ZERO;
			digital_active_out      <= selected && state_next != ST_OFF; // R14
		end
	end

	// Checks beside the logic
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_hiz_deselected;
		!selected |=> !serial_data_oe_out;
	endproperty
	a_hiz_deselected: assert property (p_hiz_deselected) else $error("output driven while deselected"); // R16

	property p_null_low;
		$rose(serial_data_oe_out) |-> !serial_data_out && $past(state_reg) == ST_SAMPLE && $past(null_edge);
	endproperty
	a_null_low: assert property (p_null_low) else $error("null bit wrong or early"); // R3

	property p_change_on_fall;
		$changed(serial_data_out) && $past(selected) |-> $past(sck_fall);
	endproperty
	a_change_on_fall: assert property (p_change_on_fall) else $error("output changed without falling clock"); // R5

	property p_sample_window;
		$fell(analog_out.sample_input) |-> $past(!selected) || ($past(sck_fall) && $past(null_edge));
	endproperty
	a_sample_window: assert property (p_sample_window) else $error("sampling ended at wrong edge"); // R2

	property p_msb_first;
		state_reg == ST_CONVERT && sck_fall && bit_idx_reg == SARSR_TOP_IDX && selected |=>
			serial_data_out == $past(decided) && code_reg[11] == $past(decided);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("top bit not from first decision"); // R4

	property p_repeat_bit;
		state_reg == ST_REPEAT && sck_fall && !rep_last && selected |=> serial_data_out == $past(rep_bit);
	endproperty
	a_repeat_bit: assert property (p_repeat_bit) else $error("repeat bit mismatch"); // R7

	property p_done_quiet;
		state_reg == ST_DONE |-> !serial_data_oe_out;
	endproperty
	a_done_quiet: assert property (p_done_quiet) else $error("output driven after sequence end"); // R8

	property p_no_restart;
		state_reg == ST_DONE && selected |=> state_reg == ST_DONE;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("restarted without select toggle"); // R9

	property p_midscale_start;
		$rose(serial_data_oe_out) |-> code_reg == SARSR_MIDSCALE;
	endproperty
	a_midscale_start: assert property (p_midscale_start) else $error("trial code not midscale"); // R13

endmodule

// ===== sarsr_host_model.sv
// Host model: drives select and bit clock, models the comparator, captures bits
`timescale 1ns/1ps
module sarsr_host_model
	import sarsr_pkg::*;
#(
	parameter int HALF = 4
) (
	// Clock and frame control
	input  wire logic                     clk_in,
	input  wire logic                     start_in,
	input  wire logic [4:0]               falls_in,
	// Analog level and device outputs
	input  wire logic [11:0]              level_in,
	input  wire sarsr_pkg::sarsr_analog_t analog_in,
	input  wire logic                     data_in,
	input  wire logic                     oe_in,
	// Pins and captured bits
	output sarsr_pkg::sarsr_pins_t        pins_out,
	output logic [23:0]                   cap_out,
	output logic [4:0]                    n_cap_out,
	output logic                          busy_out
);
	logic       sel_n_reg = 1'b1;
	logic       bclk_reg = 1'b0;
	logic [4:0] nf_reg = 5'h00;
	int         ph = 0;

	// Comparator keeps a trial bit while the level is at or above it
	assign pins_out = {sel_n_reg, bclk_reg, level_in >= analog_in.trial_code};

	// Bit clock halves of HALF cycles stay slower than the device can track
	// and inside the legal rate; it stands low between frames
	initial begin
		busy_out = 1'b0;
		cap_out = 24'h000000;
		n_cap_out = 5'h00;
	end
	always @(negedge clk_in) begin
		if (start_in && !busy_out) begin
			busy_out <= 1'b1;
			sel_n_reg <= 1'b0;
			nf_reg <= 5'h00;
			ph <= 0;
			cap_out <= 24'h000000;
			n_cap_out <= 5'h00;
		end else if (busy_out && ph < HALF - 1) begin
			ph <= ph + 1;
		end else if (busy_out && bclk_reg) begin
			ph <= 0;
			bclk_reg <= 1'b0;
			nf_reg <= nf_reg + 5'h01;
		end else if (busy_out && nf_reg == falls_in) begin
			sel_n_reg <= 1'b1;
			busy_out <= 1'b0;
		end else if (busy_out) begin
			ph <= 0;
			bclk_reg <= 1'b1;
			// Capture on the rising edge, only while the line is driven
			if (oe_in) begin
				cap_out <= {cap_out[22:0], data_in};
				n_cap_out <= n_cap_out + 5'h01;
			end
		end
	end
endmodule

// ===== sar_adc_serial_readout_bench.sv
// Self-checking bench of the serial SAR readout block
`timescale 1ns/1ps
module sar_adc_serial_readout_bench;
	import sarsr_pkg::*;
	logic          clk_in;
	logic          rst_n_in;
	logic          start;
	logic [4:0]    falls;
	logic [11:0]   level;
	sarsr_pins_t   pins;
	sarsr_analog_t analog;
	logic          data;
	logic          oe;
	logic          active;
	logic [23:0]   cap;
	logic [4:0]    n_cap;
	logic          busy;
	int            n_errors;
	int            checks_done;

	sarsr_core i_sarsr_core (.clk_in(clk_in), .rst_n_in(rst_n_in), .pins_in(pins), .serial_data_out(data),
		.serial_data_oe_out(oe), .analog_out(analog), .digital_active_out(active));
	sarsr_host_model i_sarsr_host_model (.clk_in(clk_in), .start_in(start), .falls_in(falls),
		.level_in(level), .analog_in(analog), .data_in(data), .oe_in(oe), .pins_out(pins),
		.cap_out(cap), .n_cap_out(n_cap), .busy_out(busy));

	// Clock of 100 ns
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// One frame of nf bit clock falls; n_exp bits are expected back
	task automatic frame(input logic [11:0] code, input logic [4:0] nf, input logic [4:0] n_exp);
		logic [23:0] exp;
		int          k;
		// Null, code top first, then code again from bit 1 upward
		exp = {1'b0, code, 11'h000};
		for (k = 1; k < 12; k++) begin
			exp[11-k] = code[k];
		end
		// Non-blocking so the host, which samples on the same falling edge, sees a clean value
		@(negedge clk_in);
		level <= code;
		falls <= nf;
		start <= 1'b1;
		@(negedge clk_in);
		start <= 1'b0;
		repeat (5) @(negedge clk_in);
		chk("sample_input", 24'h1, analog.sample_input);
		chk("digital_active on", 24'h1, active);
		chk("analog_power", 24'h1, analog.analog_power);
		chk("oe before null", 24'h0, oe);
		for (k = 0; k < 400 && busy; k++) begin
			@(negedge clk_in);
		end
		chk("frame end", 24'h0, busy);
		repeat (5) @(negedge clk_in);
		chk("bit count", n_exp, n_cap);
		chk("bits", exp & ~(24'hffffff >> n_exp), cap << (24 - n_exp));
		chk("oe idle", 24'h0, oe);
		chk("digital_active", 24'h0, active);
		chk("analog idle", 24'h0, analog);
		$display("test frame %h falls %0d done", code, nf);
	endtask

	// Main sequence: full frames over the code table, then short cycles
	initial begin
		rst_n_in = 1'b0;
		start = 1'b0;
		falls = 5'h00;
		level = 12'h000;
		n_errors = 0;
		checks_done = 0;
		repeat (8) @(negedge clk_in);
		rst_n_in = 1'b1;
		frame(12'hfff, 5'h1e, 5'h18);
		frame(12'h800, 5'h1e, 5'h18);
		frame(12'h7ff, 5'h1e, 5'h18);
		frame(12'h000, 5'h1e, 5'h18);
		frame(12'ha5a, 5'h1a, 5'h18);
		frame(12'h3c6, 5'h08, 5'h06);
		frame(12'h5a3, 5'h03, 5'h01);
		summarize();
	end

	// Watchdog: full frames take a few hundred cycles each, short frames under a hundred
	initial begin
		repeat (20000) @(posedge clk_in);
		n_errors++;
		$display("MISMATCH watchdog expected end seen timeout");
		summarize();
	end
endmodule
